// ### inc/gain_buffer_consts.vh
`ifndef GAIN_BUFFER_CONSTS_VH
`define GAIN_BUFFER_CONSTS_VH
// ----------------------------------------
// register indices
// ----------------------------------------
`define IDX_GAIN_CTRL      4'h0
`define IDX_BUF_INTERVAL   4'h3
`define IDX_ERROR_STATUS   4'h4
`define IDX_SUPPRESS       4'hb
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define GAIN_FIELD_HI      7
`define GAIN_FIELD_LO      4
`define MUX_FIELD_HI       2
`define MUX_FIELD_LO       0
`define GAIN_RESET         4'h0
`define GAIN_MAX_CODE      4'ha
`define OUT_MULT_RESET     1'b0
`define CMD_BUF_START_BIT  5
`define ERR_INPUT_OV       0
`define ERR_AMP_CLIP       1
`define ERR_GAIN_OVL       2
`define ERR_CLAMP          3
`define ERR_OUT_STAGE      4
`define NUM_ERR            5
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_FREQ_HZ        200000000
`define OSC_FREQ_HZ        1000000
`define CHOP_DIVIDE        4
`define OSC_DIVIDE         (`CLK_FREQ_HZ / `OSC_FREQ_HZ)
`endif

// ### rtl/gb_tick_gen.v
`include "gain_buffer_consts.vh"
`default_nettype none
// ----------------------------------------
// oscillator tick and chopper clock
// ----------------------------------------
module gb_tick_gen #(
	parameter DIVIDE = `OSC_DIVIDE
) (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       ce,
	input  wire       ext_clk_sel,
	input  wire       ext_clk_rise,
	output reg        osc_tick,
	output reg        chop_q
);
	reg  [7:0] div_q;
	reg  [1:0] chop_cnt_q;
	wire       base_tick;

	// external source replaces the internal base when selected
	assign base_tick = ext_clk_sel ? ext_clk_rise : (div_q == 8'h00);

	// divide clk down to 1 MHz, then by four for 250 kHz chopping
	always @(posedge clk) begin
		if (!rst_n) begin
			div_q      <= 8'h00;
			chop_cnt_q <= 2'h0;
			chop_q     <= 1'b0;
			osc_tick   <= 1'b0;
		end else if (ce) begin
			div_q    <= (div_q == 8'h00) ? DIVIDE[7:0] - 8'h01 : div_q - 8'h01;
			osc_tick <= base_tick;
			if (base_tick) begin
				chop_cnt_q <= chop_cnt_q + 2'h1; // [R01]
				if (chop_cnt_q[0])
					chop_q <= ~chop_q; // quarter rate, 50% duty [R01]
			end
		end
	end
endmodule
`default_nettype wire

// ### rtl/gb_err_filter.v
`include "gain_buffer_consts.vh"
`default_nettype none
// ----------------------------------------
// per-sensor suppression delay
// ----------------------------------------
module gb_err_filter (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       ce,
	input  wire       osc_tick,
	input  wire       sense,
	input  wire [7:0] delay,
	output reg        filtered
);
	reg [7:0] cnt_q;

	// condition must persist delay oscillator ticks before it counts
	always @(posedge clk) begin
		if (!rst_n) begin
			cnt_q    <= 8'h00;
			filtered <= 1'b0;
		end else if (ce) begin
			if (!sense) begin
				cnt_q    <= 8'h00;
				filtered <= 1'b0;
			end else if (cnt_q >= delay) begin
				filtered <= 1'b1; // [R15]
			end else if (osc_tick) begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ### rtl/gain_buffer_error_control.v
`include "gain_buffer_consts.vh"
`default_nettype none
// What this block does
// R01: chopper at quarter of 1 MHz oscillator
// R02: index 0 holds gain and mux address
// R03: gain codes 128 down to one eighth
// R04: gain resets to one eighth
// R05: output multiplier unity or larger, resets unity
// R06: buffer turns off after index 3 interval
// R07: command bit 5 starts buffer
// R08: trigger pin also starts buffer
// R09: busy indication while buffer engaged
// R10: separate four input fault indicators
// R11: output stage fault flag
// R12: errors held in index 4 status
// R13: latch unless latch disable set
// R14: ored errors drive interrupt pin
// R15: suppression delay from index 11
// R16: errors suppressed while buffer active
// R17: non-buffer switches set by host writes
// R18: buffer switches follow buffer automatically
// R19: interval counts oscillator, retrigger restarts
// R20: flags clear by status write or reset
module gain_buffer_error_control (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       ce,
	// register access port, already deserialised from the spi
	input  wire       wr_en,
	input  wire [3:0] wr_index,
	input  wire [7:0] wr_data,
	input  wire [3:0] rd_index,
	output reg  [7:0] rd_data,
	input  wire       cmd_valid,
	input  wire [7:0] cmd_byte,
	// configuration
	input  wire       out_gain_mult,
	input  wire       latch_disable,
	input  wire       err_pin_enable,
	input  wire       suppress_in_buffer,
	input  wire       ext_clk_sel,
	input  wire [7:0] switch_ctrl,
	// pins from outside the clock domain
	input  wire       buffer_trigger_input,
	input  wire       ext_clk_pin,
	input  wire       sense_input_ov,
	input  wire       sense_amp_clip,
	input  wire       sense_gain_ovl,
	input  wire       sense_clamp,
	input  wire       sense_out_stage,
	// outputs
	output reg  [3:0] gain_code,
	output reg  [2:0] mux_addr,
	output reg        out_mult_q,
	output reg        buffer_active_indication,
	output reg  [7:0] switch_q,
	output reg  [3:0] buf_switch_q,
	output reg        chop_clk,
	output reg        error_irq,
	output reg        input_overvoltage_flag,
	output reg        amp_output_clip_flag,
	output reg        gain_network_overload_flag,
	output reg        input_clamp_conduction_flag,
	output reg        output_stage_fault_flag
);
	// ----------------------------------------
	// timing notes for users of this block
	// ----------------------------------------
	// the oscillator tick is a one-cycle strobe, not a clock, so every
	// timer moves in whole ticks, of DIVIDE clk cycles or of the link clock when ext_clk_sel is set
	// a started interval lasts between n and n+1 ticks because the first
	// tick may fall at any point after the start; hosts that need a hard
	// maximum should program one tick less than they allow
	// pins pass two flops, so a pin event reaches the logic two clk
	// cycles late; a pulse shorter than one clk period may be missed,
	// which is acceptable for slow trigger and sensor lines
	// the trigger pin starts the buffer on its rising edge only; holding it
	// high does not keep the buffer engaged
	// a command byte with the start bit set while the buffer runs reloads
	// the full interval rather than adding to what is left
	// flags are registered copies of err_d, so they match err_q exactly;
	// a clearing write and a new fault in one cycle leave the flag set,
	// since losing a fault is worse than reporting one twice
	// live mode (latch disable) bypasses the clear path entirely, and its
	// flags drop as soon as the filtered sensor drops
	// the interrupt pin follows the same registered word, gated by its
	// enable, so it never pulses for a fault that the status word lacks
	// ce low freezes every counter and flag; the tick divider is frozen
	// too, so intervals stretch by the frozen time rather than shrink
	// gain codes above the 128 step are dropped whole, but the mux field
	// of the same write still lands, so mux stepping never stalls

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	reg  [6:0]          sync1_q;
	reg  [6:0]          sync2_q;
	reg                 trig_prev_q;
	reg                 ext_prev_q;
	wire                trig_rise;
	wire                ext_rise;
	wire [`NUM_ERR-1:0] sense_sync;
	wire [6:0]          pin_bus;

	// raw pins in one bus: sensors low, trigger and link clock on top
	assign pin_bus[`ERR_INPUT_OV]  = sense_input_ov;
	assign pin_bus[`ERR_AMP_CLIP]  = sense_amp_clip;
	assign pin_bus[`ERR_GAIN_OVL]  = sense_gain_ovl;
	assign pin_bus[`ERR_CLAMP]     = sense_clamp;
	assign pin_bus[`ERR_OUT_STAGE] = sense_out_stage;
	assign pin_bus[5]              = buffer_trigger_input;
	assign pin_bus[6]              = ext_clk_pin;

	// two stages before anything reads a pin
	always @(posedge clk) begin
		if (!rst_n) begin
			sync1_q     <= 7'h00;
			sync2_q     <= 7'h00;
			trig_prev_q <= 1'b0;
			ext_prev_q  <= 1'b0;
		end else if (ce) begin
			sync1_q     <= pin_bus;
			sync2_q     <= sync1_q;
			trig_prev_q <= sync2_q[5];
			ext_prev_q  <= sync2_q[6];
		end
	end

	assign sense_sync = sync2_q[4:0];
	assign trig_rise  = sync2_q[5] & ~trig_prev_q;
	assign ext_rise   = sync2_q[6] & ~ext_prev_q;

	// ----------------------------------------
	// oscillator and chopper
	// ----------------------------------------
	wire osc_tick;
	wire chop_w;

	// tick and chopper sit in their own module so the divider can be
	// replaced by a real oscillator input without touching the timers
	gb_tick_gen u_tick (
		.clk          (clk),
		.rst_n        (rst_n),
		.ce           (ce),
		.ext_clk_sel  (ext_clk_sel),
		.ext_clk_rise (ext_rise),
		.osc_tick     (osc_tick),
		.chop_q       (chop_w)
	);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg  [7:0] buf_interval_setting;
	reg  [7:0] suppress_delay_q;
	wire       status_wr;
	wire [7:0] status_word;

	// one decoder for the write and the read side keeps the map in one place
	function index_is;
		input [3:0] idx;
		input [3:0] target;
		begin
			index_is = (idx == target);
		end
	endfunction

	// codes above the 128 step are not implemented and are dropped
	function gain_code_ok;
		input [3:0] code;
		begin
			gain_code_ok = (code <= `GAIN_MAX_CODE);
		end
	endfunction

	assign status_wr = wr_en && index_is(wr_index, `IDX_ERROR_STATUS);
	// status word as the host reads it
	assign status_word = {2'h0, buffer_active_indication, err_q}; // [R12]

	// host writes; out-of-range gain codes are ignored
	always @(posedge clk) begin
		if (!rst_n) begin
			gain_code            <= `GAIN_RESET; // one eighth [R04]
			mux_addr             <= 3'h0;
			buf_interval_setting <= 8'h00;
			suppress_delay_q     <= 8'h00;
		end else if (ce && wr_en) begin
			if (index_is(wr_index, `IDX_GAIN_CTRL)) begin
				if (gain_code_ok(wr_data[`GAIN_FIELD_HI:`GAIN_FIELD_LO]))
					gain_code <= wr_data[`GAIN_FIELD_HI:`GAIN_FIELD_LO]; // [R02] [R03]
				mux_addr <= wr_data[`MUX_FIELD_HI:`MUX_FIELD_LO]; // [R02]
			end else if (index_is(wr_index, `IDX_BUF_INTERVAL)) begin
				buf_interval_setting <= wr_data; // [R06]
			end else if (index_is(wr_index, `IDX_SUPPRESS)) begin
				suppress_delay_q <= wr_data; // [R15]
			end
		end
	end

	// ----------------------------------------
	// current buffer timing
	// ----------------------------------------
	reg  [8:0] buf_cnt_q;
	wire       buf_start;
	wire       cmd_start;
	wire       pin_start;

	// a command bit and a pin edge are equal sources of a start
	assign cmd_start = cmd_valid && cmd_byte[`CMD_BUF_START_BIT]; // [R07]
	assign pin_start = trig_rise; // [R08]
	assign buf_start = cmd_start || pin_start;

	// counts oscillator ticks; a fresh start reloads the count
	always @(posedge clk) begin
		if (!rst_n) begin
			buf_cnt_q                <= 9'h000;
			buffer_active_indication <= 1'b0;
		end else if (ce) begin
			if (buf_start) begin
				buf_cnt_q                <= {1'b0, buf_interval_setting} + 9'h001; // [R19]
				buffer_active_indication <= 1'b1; // [R09]
			end else if (buffer_active_indication && osc_tick) begin
				buf_cnt_q <= buf_cnt_q - 9'h001;
				if (buf_cnt_q == 9'h001)
					buffer_active_indication <= 1'b0; // auto off [R06] [R09]
			end
		end
	end

	// ----------------------------------------
	// switch outputs
	// ----------------------------------------
	// buffer-side switches track buffer state, others from host
	always @(posedge clk) begin
		if (!rst_n) begin
			switch_q     <= 8'h00;
			buf_switch_q <= 4'h0;
			out_mult_q   <= `OUT_MULT_RESET; // [R05]
			chop_clk     <= 1'b0;
		end else if (ce) begin
			switch_q     <= switch_ctrl; // [R17]
			buf_switch_q <= {4{buffer_active_indication}}; // [R18]
			out_mult_q   <= out_gain_mult; // [R05]
			chop_clk     <= chop_w; // [R01]
		end
	end

	// ----------------------------------------
	// error detection
	// ----------------------------------------
	wire [`NUM_ERR-1:0] filt;
	wire [`NUM_ERR-1:0] qualified;
	reg  [`NUM_ERR-1:0] err_q;
	reg  [`NUM_ERR-1:0] err_d;
	wire                blank_now;
	integer i;

	// one filter per sensor; they share the delay so all flags age alike
	genvar g;
	generate
		for (g = 0; g < `NUM_ERR; g = g + 1) begin : g_filt
			gb_err_filter u_filt (
				.clk      (clk),
				.rst_n    (rst_n),
				.ce       (ce),
				.osc_tick (osc_tick),
				.sense    (sense_sync[g]),
				.delay    (suppress_delay_q),
				.filtered (filt[g])
			);
		end
	endgenerate

	// blanking while buffer runs avoids false overloads from switching
	assign blank_now = suppress_in_buffer & buffer_active_indication; // [R16]
	assign qualified = filt & {`NUM_ERR{~blank_now}};

	// set wins over a clearing write; write of one clears that bit
	always @* begin
		err_d = err_q;
		if (latch_disable) begin
			err_d = qualified; // live follow [R13]
		end else begin
			for (i = 0; i < `NUM_ERR; i = i + 1) begin
				if (status_wr && wr_data[i])
					err_d[i] = 1'b0; // [R20]
				if (qualified[i])
					err_d[i] = 1'b1; // held until cleared [R12] [R13]
			end
		end
	end

	// flag pins and interrupt come from the same word as the status read
	always @(posedge clk) begin
		if (!rst_n) begin
			err_q                       <= {`NUM_ERR{1'b0}};
			input_overvoltage_flag      <= 1'b0;
			amp_output_clip_flag        <= 1'b0;
			gain_network_overload_flag  <= 1'b0;
			input_clamp_conduction_flag <= 1'b0;
			output_stage_fault_flag     <= 1'b0;
			error_irq                   <= 1'b0;
		end else if (ce) begin
			err_q                       <= err_d;
			input_overvoltage_flag      <= err_d[`ERR_INPUT_OV]; // [R10]
			amp_output_clip_flag        <= err_d[`ERR_AMP_CLIP]; // [R10]
			gain_network_overload_flag  <= err_d[`ERR_GAIN_OVL]; // [R10]
			input_clamp_conduction_flag <= err_d[`ERR_CLAMP]; // [R10]
			output_stage_fault_flag     <= err_d[`ERR_OUT_STAGE]; // [R11]
			error_irq                   <= err_pin_enable & (|err_d); // [R14]
		end
	end

	// ----------------------------------------
	// register readback
	// ----------------------------------------
	// registered so the read port never shows a combinational glitch
	always @(posedge clk) begin
		if (!rst_n) begin
			rd_data <= 8'h00;
		end else if (ce) begin
			if (index_is(rd_index, `IDX_GAIN_CTRL))
				rd_data <= {gain_code, 1'b0, mux_addr};
			else if (index_is(rd_index, `IDX_BUF_INTERVAL))
				rd_data <= buf_interval_setting;
			else if (index_is(rd_index, `IDX_ERROR_STATUS))
				rd_data <= status_word; // [R12]
			else if (index_is(rd_index, `IDX_SUPPRESS))
				rd_data <= suppress_delay_q;
			else
				rd_data <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// ### verification/gb_host_model.sv
`default_nettype none
// ----
// host side: writes, commands, trigger pin, link clock
// ----
module gb_host_model (
	input  wire logic       clk,
	output logic            wr_en,
	output logic [3:0]      wr_index,
	output logic [7:0]      wr_data,
	output logic            cmd_valid,
	output logic [7:0]      cmd_byte,
	output logic            buffer_trigger_input,
	output logic            ext_clk_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	logic ext_run;
	// quiet at time zero
	initial begin
		{wr_en, wr_index, wr_data, cmd_valid, cmd_byte, buffer_trigger_input} = '0;
		ext_run = 1'b0;
		ext_clk_pin = 1'b0;
	end
	// 80 ns link clock, offset so it never lines up with clk
	initial begin
		#7.3;
		forever #40 ext_clk_pin = ext_run & ~ext_clk_pin;
	end
	// one taken edge, then released lines show inverted data
	task automatic wr(input logic [3:0] idx, input logic [7:0] dat);
		wr_en <= 1'b1;
		wr_index <= idx;
		wr_data <= dat;
		@(posedge clk);
		wr_en <= 1'b0;
		wr_index <= ~idx;
		wr_data <= ~dat;
		@(posedge clk);
	endtask
	// command byte, start bit asks for the buffer
	task automatic cmd(input logic [7:0] b);
		cmd_valid <= 1'b1;
		cmd_byte <= b;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_byte <= ~b;
		@(posedge clk);
	endtask
	// held past the two-flop sync so one edge is seen
	task automatic trig();
		buffer_trigger_input <= 1'b1;
		repeat (4) @(posedge clk);
		buffer_trigger_input <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### verification/gain_buffer_error_control_props.sv
`include "gain_buffer_consts.vh"
`default_nettype none
// ----
// port-level checks
// ----
module gb_ctrl_props (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       ce,
	input wire logic       wr_en,
	input wire logic [3:0] wr_index,
	input wire logic [7:0] wr_data,
	input wire logic       cmd_valid,
	input wire logic [7:0] cmd_byte,
	input wire logic       latch_disable,
	input wire logic       err_pin_enable,
	input wire logic       suppress_in_buffer,
	input wire logic       ext_clk_sel,
	input wire logic       sense_input_ov,
	input wire logic [3:0] gain_code,
	input wire logic [2:0] mux_addr,
	input wire logic       buffer_active_indication,
	input wire logic [3:0] buf_switch_q,
	input wire logic       chop_clk,
	input wire logic       error_irq,
	input wire logic       input_overvoltage_flag
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [9:0] chop_cnt_q;
	logic       chop_seen_q;
	// cycles since last chopper edge; first edge has no reference
	always_ff @(posedge clk) begin
		if (!rst_n || ext_clk_sel) begin
			chop_cnt_q <= 10'h0;
			chop_seen_q <= 1'b0;
		end else if ($changed(chop_clk)) begin
			chop_cnt_q <= ce ? 10'h000 : 10'h3ff; // frozen edge does not count
			chop_seen_q <= 1'b1;
		end else if (ce) begin
			chop_cnt_q <= chop_cnt_q + 10'h1;
		end
	end
	sequence ov_quiet;
		!sense_input_ov [*8];
	endsequence
	sequence blanking;
		(buffer_active_indication && suppress_in_buffer) [*8];
	endsequence
	gain_write_a: assert property (
		ce && wr_en && wr_index == `IDX_GAIN_CTRL && wr_data[7:4] <= `GAIN_MAX_CODE
		|=> gain_code == $past(wr_data[7:4]) && mux_addr == $past(wr_data[2:0]))
		else $error("gain write lost");
	buf_start_a: assert property (
		ce && cmd_valid && cmd_byte[`CMD_BUF_START_BIT] |=> buffer_active_indication)
		else $error("buffer not started");
	switch_follow_a: assert property (
		$rose(buffer_active_indication) |=> buf_switch_q != 4'h0)
		else $error("buffer switches idle");
	irq_gate_a: assert property (
		!err_pin_enable ##1 !err_pin_enable |-> !error_irq)
		else $error("interrupt pin not gated");
	flag_hold_a: assert property (
		!latch_disable && input_overvoltage_flag && !(wr_en && wr_index == `IDX_ERROR_STATUS)
		|=> latch_disable || input_overvoltage_flag)
		else $error("latched flag dropped");
	flag_clear_a: assert property (
		ov_quiet ##0 (ce && wr_en && wr_index == `IDX_ERROR_STATUS && wr_data[`ERR_INPUT_OV])
		|=> !input_overvoltage_flag)
		else $error("flag not cleared");
	blank_a: assert property (
		blanking |-> !$rose(input_overvoltage_flag))
		else $error("flag set while blanked");
	chop_period_a: assert property (
		chop_seen_q && !ext_clk_sel && $changed(chop_clk) |-> chop_cnt_q == 10'd399)
		else $error("chopper half period wrong");
endmodule
bind gain_buffer_error_control gb_ctrl_props u_props (
	.clk, .rst_n, .ce, .wr_en, .wr_index, .wr_data, .cmd_valid, .cmd_byte, .latch_disable,
	.err_pin_enable, .suppress_in_buffer, .ext_clk_sel, .sense_input_ov, .gain_code, .mux_addr,
	.buffer_active_indication, .buf_switch_q, .chop_clk, .error_irq, .input_overvoltage_flag
);
`default_nettype wire

// ### verification/gain_buffer_error_control_tb_top.sv
`default_nettype none
module gain_buffer_error_control_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        ce = 1'b1;
	logic        out_gain_mult = 1'b0;
	logic        latch_disable = 1'b0;
	logic        err_pin_enable = 1'b0;
	logic        suppress_in_buffer = 1'b0;
	logic        ext_clk_sel = 1'b0;
	logic [7:0]  switch_ctrl = 8'h00;
	logic [3:0]  rd_index = 4'h4;
	logic [4:0]  sense = 5'h00;
	wire  [3:0]  wr_index, gain_code, buf_switch_q;
	wire  [7:0]  wr_data, cmd_byte, rd_data, switch_q;
	wire  [4:0]  flags;
	wire  [2:0]  mux_addr;
	wire         wr_en, cmd_valid, buffer_trigger_input, ext_clk_pin, out_mult_q;
	wire         buffer_active_indication, chop_clk, error_irq;
	int          mismatches = 0;
	int          total_checks = 0;
	int          cycles = 0;
	// written byte, expected gain code, expected mux address
	logic [14:0] rows [6] = '{{8'h00, 4'h0, 3'h0}, {8'ha7, 4'ha, 3'h7}, {8'h35, 4'h3, 3'h5},
		{8'hf2, 4'h3, 3'h2}, {8'hb4, 4'h3, 3'h4}, {8'h51, 4'h5, 3'h1}};
	gain_buffer_error_control DUT (
		.clk, .rst_n, .ce, .wr_en, .wr_index, .wr_data, .rd_index, .rd_data, .cmd_valid,
		.cmd_byte, .out_gain_mult, .latch_disable, .err_pin_enable, .suppress_in_buffer,
		.ext_clk_sel, .switch_ctrl, .buffer_trigger_input, .ext_clk_pin,
		.sense_input_ov(sense[0]), .sense_amp_clip(sense[1]), .sense_gain_ovl(sense[2]),
		.sense_clamp(sense[3]), .sense_out_stage(sense[4]), .gain_code, .mux_addr, .out_mult_q,
		.buffer_active_indication, .switch_q, .buf_switch_q, .chop_clk, .error_irq,
		.input_overvoltage_flag(flags[0]), .amp_output_clip_flag(flags[1]),
		.gain_network_overload_flag(flags[2]), .input_clamp_conduction_flag(flags[3]),
		.output_stage_fault_flag(flags[4])
	);
	gb_host_model host (.clk, .wr_en, .wr_index, .wr_data, .cmd_valid, .cmd_byte,
		.buffer_trigger_input, .ext_clk_pin);
	// 200 MHz
	always #2.5 clk = ~clk;
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// hang guard, well above the ~3700 cycles needed
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
		total_checks++;
		if (!(got >= lo && got <= hi)) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected from %h", $time, got, lo);
		end
	endtask
	// busy cycles, sampled mid-cycle to stay clear of edge races
	task automatic busy_len(output logic [15:0] n);
		n = 16'h0;
		while (buffer_active_indication === 1'b1) begin
			@(negedge clk);
			n++;
		end
	endtask
	// clk cycles between two chopper edges
	task automatic chop_half(output logic [15:0] n);
		time t0;
		@(chop_clk);
		t0 = $time;
		@(chop_clk);
		n = 16'(($time - t0) / 5);
	endtask
	initial begin
		logic [15:0] n;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk({gain_code, out_mult_q, buffer_active_indication, flags}, 16'h0);
		foreach (rows[i]) begin
			host.wr(4'h0, rows[i][14:7]);
			chk({gain_code, mux_addr}, rows[i][6:0]);
		end
		// a write while frozen must not land; then read index 0 back
		ce <= 1'b0;
		host.wr(4'h0, 8'h12);
		chk({gain_code, mux_addr}, {4'h5, 3'h1});
		ce <= 1'b1;
		rd_index <= 4'h0;
		repeat (2) @(posedge clk);
		chk(rd_data, 8'h51);
		rd_index <= 4'h4;
		out_gain_mult <= 1'b1;
		switch_ctrl <= 8'h5a;
		repeat (3) @(posedge clk);
		chk({out_mult_q, switch_q}, 9'h15a);
		host.cmd(8'hdf);
		chk(buffer_active_indication, 1'b0);
		// four ticks, retriggered midway so restart is visible
		host.wr(4'h3, 8'h03);
		host.cmd(8'h20);
		repeat (400) @(posedge clk);
		host.cmd(8'h20);
		@(negedge clk);
		chk({buffer_active_indication, |buf_switch_q, rd_data[5]}, 3'h7);
		busy_len(n);
		rng(n, 16'd595, 16'd802);
		@(posedge clk);
		host.wr(4'h3, 8'h01);
		host.trig();
		repeat (2) @(negedge clk);
		chk(buffer_active_indication, 1'b1);
		busy_len(n);
		rng(n, 16'd190, 16'd405);
		@(posedge clk);
		host.wr(4'hb, 8'h00);
		err_pin_enable <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			sense <= 5'(1 << i);
			repeat (10) @(posedge clk);
			sense <= 5'h0;
			repeat (10) @(posedge clk);
			chk({error_irq, flags}, {1'b1, 5'(1 << i)});
			chk(rd_data, {3'h0, 5'(1 << i)});
			host.wr(4'h4, 8'h1f);
			chk(flags, 5'h0);
		end
		latch_disable <= 1'b1;
		sense <= 5'h01;
		repeat (10) @(posedge clk);
		chk(flags, 5'h01);
		sense <= 5'h0;
		repeat (10) @(posedge clk);
		chk(flags, 5'h0);
		latch_disable <= 1'b0;
		// two ticks of persistence needed before a flag
		host.wr(4'hb, 8'h02);
		sense <= 5'h10;
		repeat (150) @(posedge clk);
		sense <= 5'h0;
		repeat (10) @(posedge clk);
		chk(flags, 5'h0);
		sense <= 5'h10;
		repeat (700) @(posedge clk);
		chk(flags, 5'h10);
		sense <= 5'h0;
		repeat (10) @(posedge clk);
		host.wr(4'h4, 8'h1f);
		host.wr(4'hb, 8'h00);
		suppress_in_buffer <= 1'b1;
		host.cmd(8'h20);
		sense <= 5'h01;
		repeat (100) @(posedge clk);
		sense <= 5'h0;
		repeat (10) @(posedge clk);
		chk(flags, 5'h0);
		chop_half(n);
		rng(n, 16'd400, 16'd400);
		ext_clk_sel <= 1'b1;
		host.ext_run = 1'b1;
		chop_half(n);
		chop_half(n);
		rng(n, 16'd30, 16'd34);
		report_and_stop();
	end
endmodule
`default_nettype wire
